// >>> verilog/ddr_pre_ctrl.sv
/*
 * Controller end: issues activate, read, write and precharge requests
 * from a user port while holding per-bank spacings.
 * Assumes one request at a time; busy until it is issued.
 */
`timescale 1ns/100ps
`default_nettype none
module ddr_pre_ctrl #(
	parameter int unsigned AL = ddr_pre_pkg::AL_DEF,
	parameter int unsigned CL = ddr_pre_pkg::CL_DEF,
	parameter int unsigned BL = ddr_pre_pkg::BL_DEF,
	parameter int unsigned MR_WR = ddr_pre_pkg::MRWR_DEF
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_ce,
	input  wire logic        i_req,
	input  wire logic [3:0]  i_cmd,
	input  wire logic [1:0]  i_ba,
	input  wire logic [13:0] i_addr,
	output logic             o_busy,
	output logic             o_done,
	ddr_pre_if.ctrl          bus
);
	localparam int unsigned W = ddr_pre_pkg::CNT_W;
	localparam int unsigned RTP_EFF = ddr_pre_pkg::RTP_CYC > ddr_pre_pkg::PFETCH_GAP
		? ddr_pre_pkg::RTP_CYC : ddr_pre_pkg::PFETCH_GAP;
	localparam logic [W-1:0] RD_PRE = W'(AL + BL / 2 + RTP_EFF - 2);
	localparam logic [W-1:0] WR_PRE = W'(AL + CL - 1 + BL / 2 + ddr_pre_pkg::WR_CYC);
	localparam logic [W-1:0] WR_DAL = W'(AL + CL - 1 + BL / 2 + MR_WR);
	localparam logic [W-1:0] BURST  = W'(AL + CL + BL / 2);

	logic        pend_ff, busy_ff, done_ff;
	logic [3:0]  cmd_ff, cs_ff;
	logic [1:0]  ba_ff;
	logic [13:0] addr_ff, a_ff;
	logic [1:0]  bo_ff;
	logic [W-1:0] lock_ff;
	logic [3:0]  apb_ff;
	logic [3:0]  open_w, ras_ok, rc_ok, pre_ok, rp_ok, apf;

	wire is_pre = cmd_ff == ddr_pre_pkg::CMD_PRE;
	wire is_act = cmd_ff == ddr_pre_pkg::CMD_ACT;
	wire is_rw  = cmd_ff == ddr_pre_pkg::CMD_RD || cmd_ff == ddr_pre_pkg::CMD_WR;
	wire all_b  = addr_ff[ddr_pre_pkg::AP_BIT];
	wire [3:0] sel = 4'h1 << ba_ff;
	wire [3:0] tgt = (is_pre && all_b) ? 4'hf : sel;
	wire pre_gate = &(~tgt | (ras_ok & pre_ok));
	wire act_gate = |(sel & ~open_w & rc_ok & rp_ok & ~apb_ff);
	wire rw_gate  = |(sel & open_w & ~apb_ff);
	wire may_go = pend_ff && lock_ff == '0
		&& (is_pre ? pre_gate : is_act ? act_gate : is_rw ? rw_gate : 1'b1);
	wire issue_rw = may_go && is_rw;
	wire issue_ap = issue_rw && all_b;
	wire [W-1:0] nxt_lock = issue_ap ? BURST : (lock_ff != '0 ? lock_ff - 1'b1 : lock_ff);

	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_bank
			// mirror of the device's internal precharge point
			assign apf[b] = apb_ff[b] && ras_ok[b] && pre_ok[b];
			bank_timer #(.W(W)) u_tmr (
				.i_sys_clk (i_sys_clk),
				.i_rstn    (i_rstn),
				.i_ce      (i_ce),
				.i_act     (may_go && is_act && sel[b]),
				.i_pre     ((may_go && is_pre && tgt[b]) || apf[b]),
				.i_ld_pre  (issue_rw && sel[b]),
				.i_pre_val (cmd_ff == ddr_pre_pkg::CMD_RD ? RD_PRE : (all_b ? WR_DAL : WR_PRE)),
				.i_ras_val (W'(ddr_pre_pkg::RAS_CYC)),
				.i_rc_val  (W'(ddr_pre_pkg::RC_CYC)),
				.i_rp_val  (W'(ddr_pre_pkg::RP_CYC)),
				.o_open    (open_w[b]),
				.o_ras_ok  (ras_ok[b]),
				.o_rc_ok   (rc_ok[b]),
				.o_pre_ok  (pre_ok[b]),
				.o_rp_ok   (rp_ok[b])
			);
		end
	endgenerate

	wire take = i_req && !pend_ff;
	wire [3:0] nxt_cs = may_go ? cmd_ff : ddr_pre_pkg::CMD_NOP;
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pend_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			cmd_ff  <= ddr_pre_pkg::CMD_NOP;
			ba_ff   <= 2'h0;
			addr_ff <= 14'h0;
			cs_ff   <= ddr_pre_pkg::CMD_NOP;
			bo_ff   <= 2'h0;
			a_ff    <= 14'h0;
			lock_ff <= '0;
			apb_ff  <= 4'h0;
		end else if (i_ce) begin
			pend_ff <= take | (pend_ff & ~may_go);
			busy_ff <= take | (pend_ff & ~may_go);
			done_ff <= may_go;
			if (take) begin
				cmd_ff  <= i_cmd;
				ba_ff   <= i_ba;
				addr_ff <= i_addr;
			end
			cs_ff   <= nxt_cs;
			if (may_go) begin
				bo_ff <= ba_ff;
				a_ff  <= addr_ff;
			end
			lock_ff <= nxt_lock;
			apb_ff  <= (apb_ff & ~apf) | (issue_ap ? sel : 4'h0);
		end
	end
	assign bus.cs_n  = cs_ff[3];
	assign bus.ras_n = cs_ff[2];
	assign bus.cas_n = cs_ff[1];
	assign bus.we_n  = cs_ff[0];
	assign bus.ba    = bo_ff;
	assign bus.addr  = a_ff;
	assign o_busy    = busy_ff;
	assign o_done    = done_ff;
endmodule : ddr_pre_ctrl
`default_nettype wire

// >>> verilog/ddr_pre_pkg.sv
/*
 * Shared constants for the bank precharge and auto-precharge logic:
 * command encodings, timing figures and their cycle counts.
 * Assumes a 100 MHz system clock shared by controller and device ends.
 */
package ddr_pre_pkg;
	localparam int unsigned CLK_PERIOD_PS = 10000;
	localparam int unsigned NUM_BANKS     = 4;
	localparam int unsigned CNT_W         = 8;
	localparam int unsigned BA_W          = 2;
	// analog times in ps, converted by rounding up
	localparam int unsigned T_RAS_PS = 40000;
	localparam int unsigned T_RP_PS  = 12500;
	localparam int unsigned T_RC_PS  = 55000;
	localparam int unsigned T_RTP_PS = 7500;
	localparam int unsigned T_WR_PS  = 15000;
	localparam int unsigned RAS_CYC = (T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RP_CYC  = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RC_CYC  = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RTP_CYC = (T_RTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned WR_CYC  = (T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// mode defaults
	localparam int unsigned AL_DEF  = 0;
	localparam int unsigned CL_DEF  = 3;
	localparam int unsigned BL_DEF  = 4;
	localparam int unsigned MRWR_DEF = 3;
	localparam int unsigned PFETCH_GAP = 2;
	localparam int unsigned PRE_PRE_MIN = 1;
	// command pins {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_DES = 4'h8;
	localparam int unsigned AP_BIT = 10;
endpackage : ddr_pre_pkg

// >>> verilog/ddr_pre_if.sv
/*
 * Command link between the memory controller and the device end.
 * Assumes both ends clocked by the same system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface ddr_pre_if;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic [1:0]  ba;
	logic [13:0] addr;
	modport ctrl (output cs_n, ras_n, cas_n, we_n, ba, addr);
	modport dev  (input  cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : ddr_pre_if
`default_nettype wire

// >>> verilog/bank_timer.sv
/*
 * Per-bank down counters for tRAS, tRC, tRTP/tWR and tRP plus open state.
 * Assumes load pulses are single cycle and mutually consistent.
 */
`timescale 1ns/100ps
`default_nettype none
module bank_timer #(
	parameter int unsigned W = ddr_pre_pkg::CNT_W
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_rstn,
	input  wire logic         i_ce,
	input  wire logic         i_act,
	input  wire logic         i_pre,
	input  wire logic         i_ld_pre,
	input  wire logic [W-1:0] i_pre_val,
	input  wire logic [W-1:0] i_ras_val,
	input  wire logic [W-1:0] i_rc_val,
	input  wire logic [W-1:0] i_rp_val,
	output logic              o_open,
	output logic              o_ras_ok,
	output logic              o_rc_ok,
	output logic              o_pre_ok,
	output logic              o_rp_ok
);
	logic [W-1:0] ras_ff, rc_ff, pre_ff, rp_ff;
	logic         open_ff;
	wire  [W-1:0] nxt_ras = i_act ? i_ras_val : (ras_ff != '0 ? ras_ff - 1'b1 : ras_ff);
	wire  [W-1:0] nxt_rc  = i_act ? i_rc_val : (rc_ff != '0 ? rc_ff - 1'b1 : rc_ff);
	wire  [W-1:0] pre_dec = pre_ff != '0 ? pre_ff - 1'b1 : pre_ff;
	// keep the longer of pending and new recovery
	wire  [W-1:0] nxt_pre = (i_ld_pre && i_pre_val > pre_dec) ? i_pre_val : pre_dec;
	wire  [W-1:0] nxt_rp  = i_pre ? i_rp_val : (rp_ff != '0 ? rp_ff - 1'b1 : rp_ff);
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ras_ff  <= '0;
			rc_ff   <= '0;
			pre_ff  <= '0;
			rp_ff   <= '0;
			open_ff <= 1'b0;
		end else if (i_ce) begin
			ras_ff  <= nxt_ras;
			rc_ff   <= nxt_rc;
			pre_ff  <= nxt_pre;
			rp_ff   <= nxt_rp;
			open_ff <= i_act ? 1'b1 : (i_pre ? 1'b0 : open_ff);
		end
	end
	assign o_open   = open_ff;
	assign o_ras_ok = ras_ff == '0;
	assign o_rc_ok  = rc_ff == '0;
	assign o_pre_ok = pre_ff == '0;
	assign o_rp_ok  = rp_ff == '0;
endmodule : bank_timer
`default_nettype wire

// >>> verilog/ddr_pre_dev.sv
/*
 * Device end: decodes precharge, tracks per-bank state and runs the
 * auto-precharge engine for reads and writes with A10 set.
 * Assumes the controller keeps all spacings it is bound to.
 */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - CS RAS WE low, CAS high is precharge
// - A10 low one bank, high all banks
// - read to precharge AL+BL/2+max(RTP,2)-2
// - earliest read precharge AL+BL/2, tRAS met
// - tRTP from AL, or AL+2 at BL8
// - write to precharge WL+BL/2+tWR
// - never precharge before write recovery ends
// - explicit write spacing uses analog tWR
// - A10 with read/write selects auto-precharge
// - close bank before opening another row
// - read AP starts AL+BL/2, delayed for tRAS/tRTP
// - tRP starts at pushed-out precharge point
// - AP not before two clocks after prefetch
// - read AP starts CL before burst end
// - activate after read AP needs tRP, tRC
// - write AP after burst plus programmed WR
// - activate after write AP needs tDAL, tRC
// - AP held off until restore completes
// - no command interrupts an AP burst
// - spacings use programmed burst length
// - precharge may follow precharge after one clock
module ddr_pre_dev #(
	parameter int unsigned AL = ddr_pre_pkg::AL_DEF,
	parameter int unsigned CL = ddr_pre_pkg::CL_DEF,
	parameter int unsigned BL = ddr_pre_pkg::BL_DEF,
	parameter int unsigned MR_WR = ddr_pre_pkg::MRWR_DEF
) (
	input  wire logic  i_sys_clk,
	input  wire logic  i_rstn,
	input  wire logic  i_ce,
	ddr_pre_if.dev     bus,
	output logic [3:0] o_bank_open,
	output logic [3:0] o_bank_pre,
	output logic [3:0] o_ap_pending
);
	localparam int unsigned W = ddr_pre_pkg::CNT_W;
	localparam int unsigned RTP_EFF = ddr_pre_pkg::RTP_CYC > ddr_pre_pkg::PFETCH_GAP
		? ddr_pre_pkg::RTP_CYC : ddr_pre_pkg::PFETCH_GAP;
	// loaded one short: the count runs out the cycle before the start edge,
	// so the internal precharge lands on that edge and not one later
	localparam logic [W-1:0] RD_AP = W'(AL + BL / 2 + RTP_EFF - 3);
	localparam logic [W-1:0] WR_AP = W'(AL + CL - 1 + BL / 2 + MR_WR - 1);
	localparam logic [W-1:0] WR_RC = W'(AL + CL - 1 + BL / 2 + ddr_pre_pkg::WR_CYC - 1);
	localparam logic [W-1:0] RAS_V = W'(ddr_pre_pkg::RAS_CYC - 1);
	localparam logic [W-1:0] RC_V  = W'(ddr_pre_pkg::RC_CYC);
	localparam logic [W-1:0] RP_V  = W'(ddr_pre_pkg::RP_CYC);

	wire [3:0] cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
	wire is_pre = cmd == ddr_pre_pkg::CMD_PRE;
	wire is_act = cmd == ddr_pre_pkg::CMD_ACT;
	wire is_rd  = cmd == ddr_pre_pkg::CMD_RD;
	wire is_wr  = cmd == ddr_pre_pkg::CMD_WR;
	wire ap_bit = bus.addr[ddr_pre_pkg::AP_BIT];
	wire [3:0] sel = 4'h1 << bus.ba;
	wire [3:0] pre_hit = is_pre ? (ap_bit ? 4'hf : sel) : 4'h0;
	// plain writes hold off a later auto-precharge by the analog recovery
	wire [W-1:0] ld_val = is_rd ? RD_AP : (ap_bit ? WR_AP : WR_RC);

	logic [3:0] ap_ff;
	logic [3:0] open_w, ras_ok, rc_ok, pre_ok, rp_ok, ap_fire, ap_set;
	logic [3:0] open_ff, pre_ff, apo_ff;

	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_bank
			wire hit = sel[b];
			assign ap_set[b]  = hit && (is_rd || is_wr) && ap_bit;
			// internal precharge waits on tRAS and recovery
			assign ap_fire[b] = ap_ff[b] && ras_ok[b] && pre_ok[b];
			bank_timer #(.W(W)) u_tmr (
				.i_sys_clk (i_sys_clk),
				.i_rstn    (i_rstn),
				.i_ce      (i_ce),
				.i_act     (is_act && hit),
				.i_pre     (pre_hit[b] || ap_fire[b]),
				.i_ld_pre  (hit && (is_rd || is_wr)),
				.i_pre_val (ld_val),
				.i_ras_val (RAS_V),
				.i_rc_val  (RC_V),
				.i_rp_val  (RP_V),
				.o_open    (open_w[b]),
				.o_ras_ok  (ras_ok[b]),
				.o_rc_ok   (rc_ok[b]),
				.o_pre_ok  (pre_ok[b]),
				.o_rp_ok   (rp_ok[b])
			);
		end
	endgenerate

	wire [3:0] nxt_ap = (ap_ff & ~ap_fire) | ap_set;
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ap_ff   <= 4'h0;
			open_ff <= 4'h0;
			pre_ff  <= 4'h0;
			apo_ff  <= 4'h0;
		end else if (i_ce) begin
			ap_ff   <= nxt_ap;
			open_ff <= open_w;
			pre_ff  <= ~rp_ok;
			apo_ff  <= nxt_ap;
		end
	end
	assign o_bank_open  = open_ff;
	assign o_bank_pre   = pre_ff;
	assign o_ap_pending = apo_ff;
endmodule : ddr_pre_dev
`default_nettype wire

// >>> testbench/ddr_pre_props.sv
/* Checker for the precharge link: command spacing and device bank state.
 * Assumes link and device outputs share one clock and reset. */
`timescale 1ns/100ps
`default_nettype none
module ddr_pre_props #(
	parameter int unsigned AL    = ddr_pre_pkg::AL_DEF,
	parameter int unsigned CL    = ddr_pre_pkg::CL_DEF,
	parameter int unsigned BL    = ddr_pre_pkg::BL_DEF,
	parameter int unsigned MR_WR = ddr_pre_pkg::MRWR_DEF
) (
	input wire logic        i_sys_clk,
	input wire logic        i_rstn,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [1:0]  ba,
	input wire logic [13:0] addr,
	input wire logic [3:0]  o_bank_open,
	input wire logic [3:0]  o_bank_pre,
	input wire logic [3:0]  o_ap_pending
);
	localparam int unsigned RTP2    = ddr_pre_pkg::RTP_CYC > 2 ? ddr_pre_pkg::RTP_CYC : 2;
	localparam int unsigned RD_PRE  = AL + BL / 2 + RTP2 - 2;
	localparam int unsigned WR_PRE  = AL + CL - 1 + BL / 2 + ddr_pre_pkg::WR_CYC;
	localparam int unsigned WAP_ACT = AL + CL - 1 + BL / 2 + MR_WR + ddr_pre_pkg::RP_CYC;
	wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	wire       act = cmd == ddr_pre_pkg::CMD_ACT;
	wire       rd  = cmd == ddr_pre_pkg::CMD_RD;
	wire       wr  = cmd == ddr_pre_pkg::CMD_WR;
	wire       pre = cmd == ddr_pre_pkg::CMD_PRE;
	wire [3:0] sel = 4'h1 << ba;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	sequence ap_cmd;
		(rd || wr) && addr[10];
	endsequence
	// bank stays out of tRP until the start edge, then shows it one flop later
	sequence pre_late(p);
		!p ##RD_PRE !p ##1 p;
	endsequence
	act_open_a: assert property (act |=> ##1 o_bank_open[$past(ba, 2)]) else $error("bank not open");
	pre_all_a: assert property (pre && addr[10] |=> ##1 o_bank_pre == 4'hf) else $error("not all precharging");
	pre_one_a: assert property (pre && !addr[10] |=> ##1 o_bank_pre[$past(ba, 2)]) else $error("bank not precharging");
	ap_arm_a: assert property (ap_cmd |=> o_ap_pending[$past(ba)]) else $error("auto precharge not armed");
	no_interrupt_a: assert property (ap_cmd |=> !(act || rd || wr || pre)) else $error("burst interrupted");
	for (genvar b = 0; b < 4; b++) begin : g_bank
		// cycles since activate, read, write, precharge, write ap, read ap
		logic [5:0][7:0] age_ff;
		wire             mine = sel[b];
		wire  [5:0]      hit  = {rd && addr[10] && mine, wr && addr[10] && mine, pre && (addr[10] || mine),
			wr && mine, rd && mine, act && mine};
		always_ff @(posedge i_sys_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				age_ff <= '1;
			end else begin
				for (int k = 0; k < 6; k++) begin
					if (hit[k]) age_ff[k] <= 8'h01;
					else if (age_ff[k] != 8'hff) age_ff[k] <= age_ff[k] + 8'h01;
				end
			end
		end
		ras_gap_a: assert property (hit[3] |-> age_ff[0] >= ddr_pre_pkg::RAS_CYC) else $error("tras short");
		rd_pre_a: assert property (hit[3] |-> age_ff[1] >= RD_PRE) else $error("read to precharge short");
		wr_pre_a: assert property (hit[3] |-> age_ff[2] >= WR_PRE) else $error("write recovery short");
		rc_gap_a: assert property (hit[0] |-> age_ff[0] >= ddr_pre_pkg::RC_CYC) else $error("trc short");
		rp_gap_a: assert property (hit[0] |-> age_ff[3] >= ddr_pre_pkg::RP_CYC) else $error("trp short");
		wap_act_a: assert property (hit[0] |-> age_ff[4] >= WAP_ACT) else $error("tdal short");
		rap_act_a: assert property (hit[0] |-> age_ff[5] >= RD_PRE + ddr_pre_pkg::RP_CYC) else $error("rd ap trp short");
		rap_start_a: assert property (hit[5] && age_ff[0] >= ddr_pre_pkg::RAS_CYC && age_ff[2] >= WR_PRE - 2
			|=> pre_late(o_bank_pre[b])) else $error("read ap start wrong");
	end
endmodule : ddr_pre_props
`default_nettype wire

// >>> testbench/testbench.sv
/* Testbench: controller and device joined by the link; corner and random traffic.
 * Assumes the package default timing and a 100 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        i_sys_clk;
	logic        i_rstn;
	logic        i_req;
	logic [3:0]  i_cmd;
	logic [1:0]  i_ba;
	logic [13:0] i_addr;
	logic        o_busy;
	logic        o_done;
	logic [3:0]  o_bank_open;
	logic [3:0]  o_bank_pre;
	logic [3:0]  o_ap_pending;
	logic [3:0]  open_m;
	integer      seed;
	int          num_errors;
	int          tests_run;
	int          cycles;
	ddr_pre_if ddr_pre_if_i ();
	ddr_pre_ctrl ddr_pre_ctrl_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_req(i_req),
		.i_cmd(i_cmd), .i_ba(i_ba), .i_addr(i_addr), .o_busy(o_busy), .o_done(o_done), .bus(ddr_pre_if_i));
	ddr_pre_dev ddr_pre_dev_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(1'b1), .bus(ddr_pre_if_i),
		.o_bank_open(o_bank_open), .o_bank_pre(o_bank_pre), .o_ap_pending(o_ap_pending));
	ddr_pre_props ddr_pre_props_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .cs_n(ddr_pre_if_i.cs_n),
		.ras_n(ddr_pre_if_i.ras_n), .cas_n(ddr_pre_if_i.cas_n), .we_n(ddr_pre_if_i.we_n), .ba(ddr_pre_if_i.ba),
		.addr(ddr_pre_if_i.addr), .o_bank_open(o_bank_open), .o_bank_pre(o_bank_pre), .o_ap_pending(o_ap_pending));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict;
		if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	function automatic logic [3:0] next_open(input logic [3:0] o, input logic [3:0] c, input logic [1:0] b,
		input logic a10);
		if (c == ddr_pre_pkg::CMD_ACT) return o | (4'h1 << b);
		if (c == ddr_pre_pkg::CMD_PRE && a10) return 4'h0;
		if (c == ddr_pre_pkg::CMD_PRE || a10) return o & ~(4'h1 << b);
		return o;
	endfunction : next_open
	task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a, input logic settle);
		int n;
		do @(posedge i_sys_clk); while (o_busy !== 1'b0);
		i_req  <= 1'b1;
		i_cmd  <= c;
		i_ba   <= b;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_req <= 1'b0;
		n = 0;
		while (o_done !== 1'b1 && n < 64) begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		check({15'h0, o_done}, 16'h1);
		check({12'h0, ddr_pre_if_i.cs_n, ddr_pre_if_i.ras_n, ddr_pre_if_i.cas_n, ddr_pre_if_i.we_n}, {12'h0, c});
		check({2'h0, ddr_pre_if_i.addr}, {2'h0, a});
		if (!(c == ddr_pre_pkg::CMD_PRE && a[10])) check({14'h0, ddr_pre_if_i.ba}, {14'h0, b});
		open_m = next_open(open_m, c, b, a[10]);
		if (settle) begin
			repeat (16) @(posedge i_sys_clk);
			#1;
			check({12'h0, o_bank_open}, {12'h0, open_m});
		end
	endtask : issue
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		logic [31:0] r;
		logic [3:0]  c;
		seed = 32'h124d;
		i_rstn = 1'b0;
		i_req = 1'b0;
		i_cmd = ddr_pre_pkg::CMD_NOP;
		i_ba = 2'h0;
		i_addr = 14'h0;
		open_m = 4'h0;
		repeat (4) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		issue(ddr_pre_pkg::CMD_PRE, 2'h0, 14'h0000, 1'b0);
		issue(ddr_pre_pkg::CMD_PRE, 2'h2, 14'h0400, 1'b1);
		issue(ddr_pre_pkg::CMD_ACT, 2'h1, 14'h1234, 1'b0);
		issue(ddr_pre_pkg::CMD_RD, 2'h1, 14'h0400, 1'b1);
		issue(ddr_pre_pkg::CMD_ACT, 2'h3, 14'h0abc, 1'b0);
		issue(ddr_pre_pkg::CMD_WR, 2'h3, 14'h0010, 1'b0);
		issue(ddr_pre_pkg::CMD_PRE, 2'h3, 14'h0000, 1'b1);
		issue(ddr_pre_pkg::CMD_ACT, 2'h0, 14'h0000, 1'b1);
		issue(ddr_pre_pkg::CMD_WR, 2'h0, 14'h3fff, 1'b1);
		for (int i = 0; i < 200; i++) begin
			r = $random(seed);
			if (!open_m[r[1:0]]) c = r[16] ? ddr_pre_pkg::CMD_PRE : ddr_pre_pkg::CMD_ACT;
			else if (r[18:17] == 2'h1) c = ddr_pre_pkg::CMD_WR;
			else if (r[18:17] == 2'h2) c = ddr_pre_pkg::CMD_PRE;
			else c = ddr_pre_pkg::CMD_RD;
			issue(c, r[1:0], r[15:2], r[19]);
		end
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
